//--- logic/adcc_sar.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
// ==========================================================
// successive approximation sequencer
module adcc_sar
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link to control
    adcc_sar_if.engine sar
);
    adcc_pkg::adcc_sar_e state_r, state_nxt; // sequencer state
    logic [3:0] idx_r, idx_nxt; // bit under trial
    logic [`ADCC_RES_W-1:0] trial_r, trial_nxt; // code being built
    logic done_r, done_nxt; // completion pulse

    // ==========================================================
    // next state
    always_comb
    begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        trial_nxt = trial_r;
        done_nxt = 1'b0;
        case (state_r)
            adcc_pkg::SAR_IDLE:
            begin
                // start only honoured when idle
                if (sar.start)
                begin
                    state_nxt = adcc_pkg::SAR_SAMPLE;
                    trial_nxt = `ADCC_RES_RST;
                end
            end
            adcc_pkg::SAR_SAMPLE:
            begin
                // one divided period to settle the input
                if (sar.tick)
                begin
                    state_nxt = adcc_pkg::SAR_CONVERT;
                    idx_nxt = `ADCC_MSB_IDX;
                    trial_nxt[`ADCC_MSB_IDX] = 1'b1;
                end
            end
            adcc_pkg::SAR_CONVERT:
            begin
                if (sar.tick)
                begin
                    // drop the bit if the input is below the trial
                    if (!sar.comp)
                        trial_nxt[idx_r] = 1'b0;
                    if (idx_r == 4'h0)
                    begin
                        state_nxt = adcc_pkg::SAR_IDLE;
                        done_nxt = 1'b1;
                    end
                    else
                    begin
                        idx_nxt = idx_r - 4'h1;
                        trial_nxt[idx_r - 4'h1] = 1'b1;
                    end
                end
            end
            default:
                state_nxt = adcc_pkg::SAR_IDLE;
        endcase
        // switching off kills the conversion, no result
        if (sar.abort)
        begin
            state_nxt = adcc_pkg::SAR_IDLE;
            done_nxt = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= adcc_pkg::SAR_IDLE;
            idx_r <= 4'h0;
            trial_r <= `ADCC_RES_RST;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            trial_r <= trial_nxt;
            done_r <= done_nxt;
        end
    end

    assign sar.busy = (state_r != adcc_pkg::SAR_IDLE);
    assign sar.done = done_r;
    assign sar.result = trial_r;
    assign sar.trial = trial_r;

    // ==========================================================
    // checks
    a_start_to_busy: assert property (@(posedge clk) disable iff (rst)
        (sar.start && !sar.busy && !sar.abort) |=> sar.busy)
        else $error("start did not raise busy");
    a_done_ends_busy: assert property (@(posedge clk) disable iff (rst)
        sar.done |-> (!sar.busy && $past(sar.busy)))
        else $error("done without busy falling");
endmodule // adcc_sar
`default_nettype wire

//--- logic/adcc_top.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
module adcc_top
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // register port
    input wire logic [`ADCC_ADDR_W-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // analog front end
    input wire logic COMP_IN,
    output logic ADC_POWER_EN,
    output logic [`ADCC_RES_W-1:0] DAC_TRIAL,
    output logic [3:0] EXT_CHANNEL_SEL,
    output logic MUX_EXT_EN,
    output logic MUX_INT_EN,
    output logic MUX_GND_EN,
    output logic [1:0] REF_SOURCE_SEL,
    // pin sharing
    input wire logic [`ADCC_CH_COUNT-1:0] PIN_ANALOG_SEL,
    input wire logic [`ADCC_CH_COUNT-1:0] GPIO_OE,
    input wire logic [`ADCC_CH_COUNT-1:0] GPIO_PULLUP,
    output logic [`ADCC_CH_COUNT-1:0] PAD_OE,
    output logic [`ADCC_CH_COUNT-1:0] PAD_PULLUP_EN,
    output logic [`ADCC_CH_COUNT-1:0] PAD_ANALOG_EN
);
    // ==========================================================
    // declarations
    adcc_sar_if sar (); // link to the engine
    logic start_r, start_nxt; // start bit
    logic enable_r, enable_nxt; // converter enable
    logic justify_r, justify_nxt; // result format
    logic [3:0] chan_r, chan_nxt; // external channel select
    logic [7:0] ctl1_r, ctl1_nxt; // control one image
    logic [`ADCC_RES_W-1:0] result_r, result_nxt; // stored result
    logic [7:0] rdata_r, rdata_nxt; // read data, one cycle late
    logic [`ADCC_DIV_W-1:0] div_r, div_nxt; // prescaler count
    logic [1:0] comp_sync_r; // comparator synchroniser
    logic start_fire; // start bit fell
    logic [2:0] src_sel; // input source field
    logic [2:0] clk_sel; // clock rate field
    logic src_ground; // source codes that ground the input
    adcc_pkg::adcc_pair_s pair; // justified bytes

    // ==========================================================
    // functions
    // prescaler mask for a rate code
    function automatic logic [`ADCC_DIV_W-1:0] div_mask(input logic [2:0] code);
        logic [`ADCC_DIV_W:0] one_hot;
        one_hot = '0;
        one_hot[code] = 1'b1;
        div_mask = `ADCC_DIV_W'(one_hot - 1'b1);
    endfunction

    // justify a code into the byte pair
    function automatic adcc_pkg::adcc_pair_s justify(input logic rfs, input logic [`ADCC_RES_W-1:0] d);
        adcc_pkg::adcc_pair_s p;
        if (rfs)
        begin
            p.high = {4'h0, d[11:8]};
            p.low = d[7:0];
        end
        else
        begin
            p.high = d[11:4];
            p.low = {d[3:0], 4'h0};
        end
        justify = p;
    endfunction

    // ==========================================================
    // field views
    assign src_sel = ctl1_r[`ADCC_C1_SRC_HI:`ADCC_C1_SRC_LO];
    assign clk_sel = ctl1_r[`ADCC_C1_CLK_HI:`ADCC_C1_CLK_LO];
    assign src_ground = (src_sel >= `ADCC_SRC_GND_LO) && (src_sel <= `ADCC_SRC_GND_HI);
    assign pair = justify(justify_r, result_r);

    // start fires when a written 1 is written back to 0 while the converter is enabled
    assign start_fire = REG_WR && (REG_ADDR == `ADCC_OFS_CTL0) && start_r
        && !REG_WDATA[`ADCC_C0_START] && enable_r;

    // ==========================================================
    // comparator synchroniser, comes from the analog side
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            comp_sync_r <= 2'h0;
        else
            comp_sync_r <= {comp_sync_r[0], COMP_IN};
    end

    // ==========================================================
    // control register next values
    always_comb
    begin
        start_nxt = start_r;
        enable_nxt = enable_r;
        justify_nxt = justify_r;
        chan_nxt = chan_r;
        ctl1_nxt = ctl1_r;
        if (REG_WR)
        begin
            case (REG_ADDR)
                `ADCC_OFS_CTL0:
                begin
                    // busy bit is read only, write ignored
                    start_nxt = REG_WDATA[`ADCC_C0_START];
                    enable_nxt = REG_WDATA[`ADCC_C0_EN];
                    justify_nxt = REG_WDATA[`ADCC_C0_RFS];
                    chan_nxt = REG_WDATA[`ADCC_C0_CH_HI:`ADCC_C0_CH_LO];
                end
                `ADCC_OFS_CTL1:
                    ctl1_nxt = REG_WDATA;
                default:
                    ; // result registers and holes are read only
            endcase
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            start_r <= 1'b0;
            enable_r <= 1'b0;
            justify_r <= 1'b0;
            chan_r <= 4'h0;
            ctl1_r <= `ADCC_CTL_RST;
        end
        else
        begin
            start_r <= start_nxt;
            enable_r <= enable_nxt;
            justify_r <= justify_nxt;
            chan_r <= chan_nxt;
            ctl1_r <= ctl1_nxt;
        end
    end

    // ==========================================================
    // result and prescaler next values
    always_comb
    begin
        result_nxt = result_r;
        // a disabled converter never touches the result
        if (sar.done && enable_r)
            result_nxt = sar.result;
        // free running prescaler; wraps at 2^7
        div_nxt = div_r + `ADCC_DIV_W'(1);
    end

    // ==========================================================
    // result and prescaler registers
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            result_r <= `ADCC_RES_RST;
            div_r <= '0;
        end
        else
        begin
            result_r <= result_nxt;
            div_r <= div_nxt;
        end
    end

    // ==========================================================
    // read data next value, zero unless a read was made
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (REG_RD)
        begin
            case (REG_ADDR)
                `ADCC_OFS_RES_LOW:
                    rdata_nxt = pair.low;
                `ADCC_OFS_RES_HIGH:
                    rdata_nxt = pair.high;
                `ADCC_OFS_CTL0:
                    rdata_nxt = {start_r, sar.busy, enable_r, justify_r, chan_r};
                `ADCC_OFS_CTL1:
                    rdata_nxt = ctl1_r;
                default:
                    rdata_nxt = 8'h00; // unmapped reads as zero
            endcase
        end
    end

    // ==========================================================
    // read data register
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end
    assign REG_RDATA = rdata_r;

    // ==========================================================
    // engine hookup
    assign sar.start = start_fire;
    assign sar.abort = !enable_r;
    // tick when the low code bits of the count are all ones
    assign sar.tick = ((div_r & div_mask(clk_sel)) == div_mask(clk_sel));
    assign sar.comp = comp_sync_r[1];

    adcc_sar u_sar
    (
        .clk (SYS_CLK),
        .rst (RESET),
        .sar (sar.engine)
    );

    // ==========================================================
    // analog front end steering
    assign ADC_POWER_EN = enable_r;
    assign DAC_TRIAL = sar.trial;
    assign REF_SOURCE_SEL = ctl1_r[`ADCC_C1_REF_HI:`ADCC_C1_REF_LO];
    assign EXT_CHANNEL_SEL = chan_r;
    // codes above nine leave the external input floating
    assign MUX_EXT_EN = !src_ground && (src_sel != `ADCC_SRC_INT) && (chan_r <= `ADCC_CH_LAST);
    assign MUX_INT_EN = (src_sel == `ADCC_SRC_INT);
    assign MUX_GND_EN = src_ground;

    // ==========================================================
    // pin sharing, per pin
    genvar gi;
    generate
        for (gi = 0; gi < `ADCC_CH_COUNT; gi++)
        begin : g_pin
            // analog use removes drive and pull-high outright
            assign PAD_OE[gi] = GPIO_OE[gi] && !PIN_ANALOG_SEL[gi];
            assign PAD_PULLUP_EN[gi] = GPIO_PULLUP[gi] && !PIN_ANALOG_SEL[gi];
            assign PAD_ANALOG_EN[gi] = PIN_ANALOG_SEL[gi];
        end
    endgenerate

    // ==========================================================
    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    a_result_hold_off: assert property (!enable_r |=> $stable(result_r))
        else $error("result changed while disabled");
    a_result_on_done: assert property ((sar.done && enable_r) |=> (result_r == $past(sar.result)))
        else $error("result not stored at done");
    a_high_right_zero: assert property ((REG_RD && REG_ADDR == `ADCC_OFS_RES_HIGH && justify_r)
        |=> (REG_RDATA[7:4] == 4'h0 && REG_RDATA[3:0] == $past(result_r[11:8])))
        else $error("right justified high byte wrong");
    a_low_left_zero: assert property ((REG_RD && REG_ADDR == `ADCC_OFS_RES_LOW && !justify_r)
        |=> (REG_RDATA[3:0] == 4'h0 && REG_RDATA[7:4] == $past(result_r[3:0])))
        else $error("left justified low byte wrong");
    a_one_source: assert property ($onehot0({MUX_EXT_EN, MUX_INT_EN, MUX_GND_EN}))
        else $error("more than one source routed");
    a_internal_code: assert property ((src_sel == `ADCC_SRC_INT) |-> (MUX_INT_EN && !MUX_EXT_EN))
        else $error("internal source not routed");
    a_ext_channel: assert property (MUX_EXT_EN |-> (EXT_CHANNEL_SEL == chan_r && chan_r <= `ADCC_CH_LAST))
        else $error("external channel mismatch");
    a_pin_release: assert property (((PAD_OE | PAD_PULLUP_EN) & PIN_ANALOG_SEL) == '0)
        else $error("analog pin still driven or pulled");
    a_pullup_off: assert property (PIN_ANALOG_SEL[0] |-> !PAD_PULLUP_EN[0])
        else $error("pull-high left on analog pin");
    a_full_rate: assert property ((clk_sel == 3'h0) |-> sar.tick)
        else $error("undivided clock missed a tick");
    a_slow_rate: assert property ((clk_sel == 3'h7 && sar.tick) |=> !sar.tick [*8])
        else $error("divide by 128 ticked early");
    a_power_busy: assert property (!enable_r |=> !sar.busy)
        else $error("busy while powered off");
    a_start_busy: assert property (start_fire |=> sar.busy)
        else $error("start did not set busy");
    a_busy_source: assert property (($rose(sar.busy)) |-> $past(start_fire))
        else $error("busy rose without start");
endmodule // adcc_top
`default_nettype wire

//--- pkg/adcc_params.svh
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
// ==========================================================
// widths
`define ADCC_RES_W 12
`define ADCC_CH_COUNT 10
`define ADCC_ADDR_W 3
// ==========================================================
// register offsets
`define ADCC_OFS_RES_LOW 3'h0
`define ADCC_OFS_RES_HIGH 3'h1
`define ADCC_OFS_CTL0 3'h2
`define ADCC_OFS_CTL1 3'h3
// ==========================================================
// control zero field positions
`define ADCC_C0_START 7
`define ADCC_C0_BUSY 6
`define ADCC_C0_EN 5
`define ADCC_C0_RFS 4
`define ADCC_C0_CH_HI 3
`define ADCC_C0_CH_LO 0
// ==========================================================
// control one field positions
`define ADCC_C1_SRC_HI 7
`define ADCC_C1_SRC_LO 5
`define ADCC_C1_REF_HI 4
`define ADCC_C1_REF_LO 3
`define ADCC_C1_CLK_HI 2
`define ADCC_C1_CLK_LO 0
// ==========================================================
// codes and reset values
`define ADCC_SRC_INT 3'h1
`define ADCC_SRC_GND_LO 3'h2
`define ADCC_SRC_GND_HI 3'h4
`define ADCC_CH_LAST 4'h9
`define ADCC_CTL_RST 8'h00
`define ADCC_RES_RST 12'h000
`define ADCC_MSB_IDX 4'hb
`define ADCC_DIV_W 7
`endif

//--- pkg/adcc_pkg.sv
`default_nettype none
package adcc_pkg;
    // conversion engine states
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} adcc_sar_e;
    // justified byte pair
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } adcc_pair_s;
endpackage
`default_nettype wire

//--- pkg/adcc_sar_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
// ==========================================================
// control side to conversion engine
interface adcc_sar_if;
    logic start; // one-cycle go
    logic abort; // converter switched off
    logic tick; // divided conversion clock pulse
    logic comp; // synchronised comparator
    logic busy; // conversion running
    logic done; // one-cycle result valid
    logic [`ADCC_RES_W-1:0] result; // final code
    logic [`ADCC_RES_W-1:0] trial; // dac trial code
    modport ctrl (output start, abort, tick, comp, input busy, done, result, trial);
    modport engine (input start, abort, tick, comp, output busy, done, result, trial);
endinterface
`default_nettype wire

//--- verification/adcc_testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
// ==========================================================
// self-checking bench for the converter control block
module testbench;
    // clock, reset and register port
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    // analog side
    logic comp_in = 1'b0;
    logic adc_power_en;
    logic [11:0] dac_trial;
    logic [3:0] ext_channel_sel;
    logic mux_ext_en;
    logic mux_int_en;
    logic mux_gnd_en;
    logic [1:0] ref_source_sel;
    // pin sharing
    logic [9:0] pin_analog_sel = 10'h000;
    logic [9:0] gpio_oe = 10'h000;
    logic [9:0] gpio_pullup = 10'h000;
    logic [9:0] pad_oe;
    logic [9:0] pad_pullup_en;
    logic [9:0] pad_analog_en;
    // bench state
    logic [11:0] target = 12'h000; // analog level the comparator model stands for
    int n_mismatch = 0;
    int samples_checked = 0;

    adcc_top dut_u
    (
        .SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .COMP_IN(comp_in),
        .ADC_POWER_EN(adc_power_en), .DAC_TRIAL(dac_trial), .EXT_CHANNEL_SEL(ext_channel_sel),
        .MUX_EXT_EN(mux_ext_en), .MUX_INT_EN(mux_int_en), .MUX_GND_EN(mux_gnd_en),
        .REF_SOURCE_SEL(ref_source_sel), .PIN_ANALOG_SEL(pin_analog_sel), .GPIO_OE(gpio_oe),
        .GPIO_PULLUP(gpio_pullup), .PAD_OE(pad_oe), .PAD_PULLUP_EN(pad_pullup_en),
        .PAD_ANALOG_EN(pad_analog_en)
    );

    // ==========================================================
    // 125 MHz clock
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    // comparator model: registered, so a slow prescaler code is needed
    always @(posedge sys_clk)
    begin
        comp_in <= (target >= dac_trial);
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // data stands only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // start with enable set, then poll busy under a bound
    task automatic run_conversion(input logic [11:0] t, input logic [7:0] ctl);
        logic [7:0] d;
        int n;
        target = t;
        reg_write(`ADCC_OFS_CTL0, ctl | 8'ha0);
        reg_write(`ADCC_OFS_CTL0, ctl | 8'h20);
        reg_read(`ADCC_OFS_CTL0, d);
        chk("busy after start", 12'h001, {11'h000, d[6]});
        n = 0;
        while (d[6] === 1'b1 && n < 200)
        begin
            reg_read(`ADCC_OFS_CTL0, d);
            n++;
        end
        if (n >= 200)
        begin
            n_mismatch++;
            $display("unexpected busy timeout: expected 0 seen 1");
            tally_and_finish();
        end
        chk("busy after end", 12'h000, {11'h000, d[6]});
    endtask

    // ==========================================================
    // scenarios
    task automatic test_reset_values();
        logic [7:0] d;
        for (int a = 0; a < 8; a++)
        begin
            reg_read(a[2:0], d);
            chk("reset read", 12'h000, {4'h0, d});
        end
        chk("power after reset", 12'h000, {11'h000, adc_power_en});
        chk("trial after reset", 12'h000, dac_trial);
        $display("test reset values done");
    endtask

    task automatic test_source_select();
        logic [7:0] d;
        for (int s = 0; s < 8; s++)
        begin
            reg_write(`ADCC_OFS_CTL1, {s[2:0], 2'b10, 3'h0});
            chk("internal route", {11'h000, s == 1}, {11'h000, mux_int_en});
            chk("ground route", {11'h000, s >= 2 && s <= 4}, {11'h000, mux_gnd_en});
            chk("external route", {11'h000, s == 0 || s >= 5}, {11'h000, mux_ext_en});
            chk("single route", 12'h001, {11'h000, $onehot({mux_int_en, mux_gnd_en, mux_ext_en})});
            chk("reference field", 12'h002, {10'h000, ref_source_sel});
            reg_read(`ADCC_OFS_CTL1, d);
            chk("control one readback", {4'h0, s[2:0], 5'h10}, {4'h0, d});
        end
        reg_write(`ADCC_OFS_CTL1, 8'h00);
        reg_write(`ADCC_OFS_CTL0, 8'h09);
        chk("channel nine", 12'h009, {8'h00, ext_channel_sel});
        chk("channel nine routed", 12'h001, {11'h000, mux_ext_en});
        reg_write(`ADCC_OFS_CTL0, 8'h4a);
        chk("channel ten routed", 12'h000, {11'h000, mux_ext_en});
        reg_read(`ADCC_OFS_CTL0, d);
        chk("busy not writable", 12'h00a, {4'h0, d});
        $display("test source select done");
    endtask

    task automatic test_conversion_formats();
        logic [7:0] hi;
        logic [7:0] lo;
        reg_write(`ADCC_OFS_CTL1, 8'h03);
        run_conversion(12'ha5c, 8'h02);
        chk("power while enabled", 12'h001, {11'h000, adc_power_en});
        chk("trial at end", 12'ha5c, dac_trial);
        reg_read(`ADCC_OFS_RES_HIGH, hi);
        reg_read(`ADCC_OFS_RES_LOW, lo);
        chk("left justified", 12'h000, {4'h0, hi} ^ 12'h0a5);
        chk("left low nibble zero", 12'h0c0, {4'h0, lo});
        reg_write(`ADCC_OFS_CTL0, 8'h32);
        reg_read(`ADCC_OFS_RES_HIGH, hi);
        reg_read(`ADCC_OFS_RES_LOW, lo);
        chk("right high zero-filled", 12'h00a, {4'h0, hi});
        chk("right justified low", 12'h05c, {4'h0, lo});
        reg_write(`ADCC_OFS_RES_HIGH, 8'hff);
        reg_read(`ADCC_OFS_RES_HIGH, hi);
        chk("result read-only", 12'h00a, {4'h0, hi});
        run_conversion(12'hfff, 8'h10);
        reg_read(`ADCC_OFS_RES_HIGH, hi);
        reg_read(`ADCC_OFS_RES_LOW, lo);
        chk("full-scale code", 12'hfff, {hi[3:0], lo});
        $display("test conversion formats done");
    endtask

    task automatic test_disable_abort();
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] d;
        target = 12'h123;
        reg_write(`ADCC_OFS_CTL0, 8'hb0);
        reg_write(`ADCC_OFS_CTL0, 8'h30);
        repeat (20) @(posedge sys_clk);
        reg_write(`ADCC_OFS_CTL0, 8'h10);
        chk("power off", 12'h000, {11'h000, adc_power_en});
        reg_read(`ADCC_OFS_CTL0, d);
        chk("busy after abort", 12'h000, {11'h000, d[6]});
        reg_write(`ADCC_OFS_CTL0, 8'h90);
        reg_write(`ADCC_OFS_CTL0, 8'h10);
        reg_read(`ADCC_OFS_CTL0, d);
        chk("start while disabled", 12'h000, {11'h000, d[6]});
        // slowest rate code, so the divide by 128 window is exercised
        reg_write(`ADCC_OFS_CTL1, 8'h07);
        repeat (150) @(posedge sys_clk);
        reg_read(`ADCC_OFS_RES_HIGH, hi);
        reg_read(`ADCC_OFS_RES_LOW, lo);
        chk("result held", 12'hfff, {hi[3:0], lo});
        $display("test disable abort done");
    endtask

    task automatic test_pin_sharing();
        @(posedge sys_clk);
        pin_analog_sel <= 10'h2a5;
        gpio_oe <= 10'h3f0;
        gpio_pullup <= 10'h18f;
        @(posedge sys_clk);
        #1;
        chk("pad output enable", {2'h0, 10'h3f0 & ~10'h2a5}, {2'h0, pad_oe});
        chk("pad pull-high", {2'h0, 10'h18f & ~10'h2a5}, {2'h0, pad_pullup_en});
        chk("pad analog", 12'h2a5, {2'h0, pad_analog_en});
        $display("test pin sharing done");
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        test_reset_values();
        test_source_select();
        test_conversion_formats();
        test_disable_abort();
        test_pin_sharing();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
